/* core/lip_gpio_top.sv */
// Latched I/O ports with alternate functions, AXI4-Lite register slave.
// Assumes synchronous pins, peripherals on core_clk, testbench resolves wires.
//
// Function
// [R1] First port has eight two-way pins, each with a writable output latch.
// [R2] Software sets first-port latch to one before serial or UART output use.
// [R3] First-port input use: set latch one, then clear output control to zero.
// [R4] Second port has six two-way pins with latch and output-control bits.
// [R5] Software sets second-port latch to one before timer or serial output use.
// [R6] Second-port input use: clear output control only after latch set to one.
// [R7] Third port starts as four two-way pins, each with output latch.
// [R8] First port bits 7,6,5: serial clock 1, UART TX/out 1, UART RX/in 1.
// [R9] First port bit 3 feeds timer 2, bits 2..0 feed external irqs 2..0.
// [R10] Second port: bit5 timer 1, bit4 timer 3 and irq 3, bit3 timer 5.
// [R11] Second port bits 2,1,0: serial clock 2, serial in 2, serial out 2.
// [R12] Mode-select test pin held low for normal microcontroller operation.
// [R13] Serial programming mode executes boot program from built-in boot memory.
// [R14] Third-port input use: clear output control after setting latch to one.
// [R15] Control zero with latch one releases pin so outside level reads back.
`timescale 1ns/1ps
module lip_gpio_top (
	input  wire logic                        core_clk,       // Core clock
	input  wire logic                        sys_rst,        // Sync reset
	input  wire logic [lip_pkg::ADDR_W-1:0]  s_axi_awaddr,   // Write address
	input  wire logic                        s_axi_awvalid,  // Write addr valid
	output logic                             s_axi_awready,  // Write addr ready
	input  wire logic [lip_pkg::DATA_W-1:0]  s_axi_wdata,    // Write data
	input  wire logic [3:0]                  s_axi_wstrb,    // Byte strobes
	input  wire logic                        s_axi_wvalid,   // Write data valid
	output logic                             s_axi_wready,   // Write data ready
	output logic [1:0]                       s_axi_bresp,    // Write response
	output logic                             s_axi_bvalid,   // Response valid
	input  wire logic                        s_axi_bready,   // Response ready
	input  wire logic [lip_pkg::ADDR_W-1:0]  s_axi_araddr,   // Read address
	input  wire logic                        s_axi_arvalid,  // Read addr valid
	output logic                             s_axi_arready,  // Read addr ready
	output logic [lip_pkg::DATA_W-1:0]       s_axi_rdata,    // Read data
	output logic [1:0]                       s_axi_rresp,    // Read response
	output logic                             s_axi_rvalid,   // Read valid
	input  wire logic                        s_axi_rready,   // Read ready
	input  wire logic [7:0]                  port0PinIn,     // First port level
	output logic      [7:0]                  port0PinOut,    // First port drive
	output logic      [7:0]                  port0PinOe,     // First port enable
	input  wire logic [5:0]                  port1PinIn,     // Second port level
	output logic      [5:0]                  port1PinOut,    // Second port drive
	output logic      [5:0]                  port1PinOe,     // Second port enable
	input  wire logic [3:0]                  port2PinIn,     // Third port level
	output logic      [3:0]                  port2PinOut,    // Third port drive
	output logic      [3:0]                  port2PinOe,     // Third port enable
	input  wire lip_pkg::lip_alt_out_t       altOut,         // Peripheral drives
	output lip_pkg::lip_alt_in_t             altIn_ff,       // Peripheral inputs
	input  wire logic                        testPin,        // Mode-select pin
	output logic                             bootRomSel_ff   // Fetch from boot memory
);

	// ==========================================================
	// Register state
	logic [7:0]                     port0OutputLatch_ff, port0OutputControl_ff;
	logic [5:0]                     port1OutputLatch_ff, port1OutputControl_ff;
	logic [3:0]                     port2OutputLatch_ff, port2OutputControl_ff;
	logic [7:0]                     port0Read, alt0;
	logic [5:0]                     port1Read, alt1;
	logic [3:0]                     port2Read;
	lip_pkg::lip_mode_t             mode_ff;

	// ==========================================================
	// AXI4-Lite slave state
	logic [lip_pkg::ADDR_W-1:0]     awAddr_ff;
	logic [lip_pkg::DATA_W-1:0]     wData_ff;
	logic                           wLane0_ff, awHeld_ff, wHeld_ff;
	logic                           awTake, wTake, arTake, doWrite, wrEn;
	logic                           nxt_awHeld, nxt_wHeld, nxt_bValid, nxt_rValid;

	// Known register offset check
	function automatic logic isMapped(input logic [lip_pkg::ADDR_W-1:0] a);
		isMapped = (a == lip_pkg::OFS_P0_LATCH) || (a == lip_pkg::OFS_P0_CTRL) ||
		           (a == lip_pkg::OFS_P0_PINS)  || (a == lip_pkg::OFS_P1_LATCH) ||
		           (a == lip_pkg::OFS_P1_CTRL)  || (a == lip_pkg::OFS_P1_PINS)  ||
		           (a == lip_pkg::OFS_P2_LATCH) || (a == lip_pkg::OFS_P2_CTRL)  ||
		           (a == lip_pkg::OFS_P2_PINS)  || (a == lip_pkg::OFS_MODE);
	endfunction

	// Handshake terms
	assign awTake     = s_axi_awvalid & s_axi_awready;
	assign wTake      = s_axi_wvalid & s_axi_wready;
	assign arTake     = s_axi_arvalid & s_axi_arready;
	assign doWrite    = awHeld_ff & wHeld_ff & ~s_axi_bvalid;
	assign wrEn       = doWrite & wLane0_ff;
	assign nxt_awHeld = awTake | (awHeld_ff & ~doWrite);
	assign nxt_wHeld  = wTake | (wHeld_ff & ~doWrite);
	assign nxt_bValid = doWrite | (s_axi_bvalid & ~s_axi_bready);
	assign nxt_rValid = arTake | (s_axi_rvalid & ~s_axi_rready);

	// Write channel capture and response
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			awHeld_ff     <= 1'b0;
			wHeld_ff      <= 1'b0;
			awAddr_ff     <= '0;
			wData_ff      <= '0;
			wLane0_ff     <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= lip_pkg::RESP_OKAY;
		end else begin
			awHeld_ff     <= nxt_awHeld;
			wHeld_ff      <= nxt_wHeld;
			s_axi_awready <= ~nxt_awHeld & ~nxt_bValid;
			s_axi_wready  <= ~nxt_wHeld & ~nxt_bValid;
			s_axi_bvalid  <= nxt_bValid;
			if (awTake) begin
				awAddr_ff <= s_axi_awaddr;
			end
			if (wTake) begin
				wData_ff  <= s_axi_wdata;
				wLane0_ff <= s_axi_wstrb[0];
			end
			if (doWrite) begin
				s_axi_bresp <= isMapped(awAddr_ff) ? lip_pkg::RESP_OKAY : lip_pkg::RESP_SLVERR;
			end
		end
	end

	// Read channel
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= lip_pkg::RESP_OKAY;
		end else begin
			s_axi_arready <= ~nxt_rValid;
			s_axi_rvalid  <= nxt_rValid;
			if (arTake) begin
				s_axi_rresp <= isMapped(s_axi_araddr) ? lip_pkg::RESP_OKAY : lip_pkg::RESP_SLVERR;
				case (s_axi_araddr)
					lip_pkg::OFS_P0_LATCH: s_axi_rdata <= {24'h000000, port0OutputLatch_ff};
					lip_pkg::OFS_P0_CTRL:  s_axi_rdata <= {24'h000000, port0OutputControl_ff};
					lip_pkg::OFS_P0_PINS:  s_axi_rdata <= {24'h000000, port0Read};
					lip_pkg::OFS_P1_LATCH: s_axi_rdata <= {26'h0, port1OutputLatch_ff};
					lip_pkg::OFS_P1_CTRL:  s_axi_rdata <= {26'h0, port1OutputControl_ff};
					lip_pkg::OFS_P1_PINS:  s_axi_rdata <= {26'h0, port1Read};
					lip_pkg::OFS_P2_LATCH: s_axi_rdata <= {28'h0000000, port2OutputLatch_ff};
					lip_pkg::OFS_P2_CTRL:  s_axi_rdata <= {28'h0000000, port2OutputControl_ff};
					lip_pkg::OFS_P2_PINS:  s_axi_rdata <= {28'h0000000, port2Read};
					lip_pkg::OFS_MODE:     s_axi_rdata <= {31'h0, mode_ff == lip_pkg::LIP_MODE_PROM};
					default:               s_axi_rdata <= 32'h00000000;
				endcase
			end
		end
	end

	// ==========================================================
	// Port latches and output controls
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			port0OutputLatch_ff   <= lip_pkg::P0_LATCH_RST;
			port0OutputControl_ff <= lip_pkg::P0_CTRL_RST;
			port1OutputLatch_ff   <= lip_pkg::P1_LATCH_RST;
			port1OutputControl_ff <= lip_pkg::P1_CTRL_RST;
			port2OutputLatch_ff   <= lip_pkg::P2_LATCH_RST;
			port2OutputControl_ff <= lip_pkg::P2_CTRL_RST;
		end else if (wrEn) begin
			case (awAddr_ff)
				lip_pkg::OFS_P0_LATCH: port0OutputLatch_ff   <= wData_ff[7:0];   // [R1]
				lip_pkg::OFS_P0_CTRL:  port0OutputControl_ff <= wData_ff[7:0];
				lip_pkg::OFS_P1_LATCH: port1OutputLatch_ff   <= wData_ff[5:0];   // [R4]
				lip_pkg::OFS_P1_CTRL:  port1OutputControl_ff <= wData_ff[5:0];   // [R4]
				lip_pkg::OFS_P2_LATCH: port2OutputLatch_ff   <= wData_ff[3:0];   // [R7]
				lip_pkg::OFS_P2_CTRL:  port2OutputControl_ff <= wData_ff[3:0];
				default: ;
			endcase
		end
	end

	// ==========================================================
	// Peripheral drives merged into latch value
	always_comb begin
		alt0                   = 8'hFF;
		alt0[lip_pkg::B0_SER_CLK_ONE] = altOut.serialClockOne;  // [R8]
		alt0[lip_pkg::B0_SER_OUT_ONE] = altOut.serialOutOne;    // [R8]
		alt1                          = 6'h3F;
		alt1[lip_pkg::B1_TMR_FIVE]    = altOut.timerFiveWave;   // [R10]
		alt1[lip_pkg::B1_SER_CLK_TWO] = altOut.serialClockTwo;  // [R11]
		alt1[lip_pkg::B1_SER_OUT_TWO] = altOut.serialOutTwo;    // [R11]
	end

	// Pin drivers, release when control zero and latch one
	lip_pin_slice #(.W(lip_pkg::P0_W)) u_port0 (        // [R15]
		.core_clk  (core_clk),
		.sys_rst   (sys_rst),
		.latchBits (port0OutputLatch_ff),
		.ctrlBits  (port0OutputControl_ff),
		.altOut    (alt0),
		.pinIn     (port0PinIn),
		.pinOut    (port0PinOut),
		.pinOe     (port0PinOe),
		.pinRead   (port0Read)
	);
	lip_pin_slice #(.W(lip_pkg::P1_W)) u_port1 (
		.core_clk  (core_clk),
		.sys_rst   (sys_rst),
		.latchBits (port1OutputLatch_ff),
		.ctrlBits  (port1OutputControl_ff),
		.altOut    (alt1),
		.pinIn     (port1PinIn),
		.pinOut    (port1PinOut),
		.pinOe     (port1PinOe),
		.pinRead   (port1Read)
	);
	lip_pin_slice #(.W(lip_pkg::P2_W)) u_port2 (
		.core_clk  (core_clk),
		.sys_rst   (sys_rst),
		.latchBits (port2OutputLatch_ff),
		.ctrlBits  (port2OutputControl_ff),
		.altOut    (4'hF),
		.pinIn     (port2PinIn),
		.pinOut    (port2PinOut),
		.pinOe     (port2PinOe),
		.pinRead   (port2Read)
	);

	// Pin levels routed to peripheral inputs
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			altIn_ff <= '0;
		end else begin
			altIn_ff.serialClockOne  <= port0PinIn[lip_pkg::B0_SER_CLK_ONE];  // [R8]
			altIn_ff.serialInOne     <= port0PinIn[lip_pkg::B0_SER_IN_ONE];   // [R8]
			altIn_ff.timerTwoInput   <= port0PinIn[lip_pkg::B0_TMR_TWO];      // [R9]
			altIn_ff.extIrqTwo       <= port0PinIn[lip_pkg::B0_IRQ2];  // [R9]
			altIn_ff.extIrqOne       <= port0PinIn[lip_pkg::B0_IRQ1];  // [R9]
			altIn_ff.extIrqZero      <= port0PinIn[lip_pkg::B0_IRQ0];  // [R9]
			altIn_ff.timerOneInput   <= port1PinIn[lip_pkg::B1_TMR_ONE];      // [R10]
			altIn_ff.timerThreeInput <= port1PinIn[lip_pkg::B1_TMR_THREE];    // [R10]
			altIn_ff.extIrqThree     <= port1PinIn[lip_pkg::B1_TMR_THREE];    // [R10]
			altIn_ff.timerFiveInput  <= port1PinIn[lip_pkg::B1_TMR_FIVE];     // [R10]
			altIn_ff.serialClockTwo  <= port1PinIn[lip_pkg::B1_SER_CLK_TWO];  // [R11]
			altIn_ff.serialInTwo     <= port1PinIn[lip_pkg::B1_SER_IN_TWO];   // [R11]
		end
	end

	// ==========================================================
	// Operating mode from test pin, low means normal operation
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			mode_ff       <= lip_pkg::LIP_MODE_MCU;
			bootRomSel_ff <= 1'b0;
		end else begin
			mode_ff       <= testPin ? lip_pkg::LIP_MODE_PROM : lip_pkg::LIP_MODE_MCU;  // [R12]
			bootRomSel_ff <= testPin;                                                  // [R13]
		end
	end

	// ==========================================================
	// Assertions
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	a_port0_latch_write: assert property (wrEn && awAddr_ff == lip_pkg::OFS_P0_LATCH  // [R1]
		|=> port0OutputLatch_ff == $past(wData_ff[7:0]))
		else $error("first port latch not written");
	a_port1_push_pull: assert property (port1OutputControl_ff == 6'h3F               // [R4]
		|=> port1PinOe == 6'h3F && port1PinOut == $past(port1OutputLatch_ff & alt1))
		else $error("second port not driving latch value");
	a_port2_latch_drive: assert property (port2OutputControl_ff == 4'hF ##1 port2OutputControl_ff == 4'hF  // [R7]
		|=> port2PinOut == $past(port2OutputLatch_ff, 1))
		else $error("third port drive not from latch");
	a_pin_release: assert property ((port0PinOe & $past(~port0OutputControl_ff & port0OutputLatch_ff & alt0))
		== 8'h00)                                                                    // [R15]
		else $error("released pin still driven");
	a_serial_one_out: assert property (port0OutputControl_ff[6] && port0OutputLatch_ff[6]  // [R8]
		|=> port0PinOut[6] == $past(altOut.serialOutOne))
		else $error("serial out 1 not on first port bit 6");
	a_irq_route: assert property ({altIn_ff.timerTwoInput, altIn_ff.extIrqTwo, altIn_ff.extIrqOne,
		altIn_ff.extIrqZero} == $past(port0PinIn[3:0]))                               // [R9]
		else $error("first port low bits misrouted");
	a_timer_route: assert property (altIn_ff.extIrqThree == altIn_ff.timerThreeInput &&
		altIn_ff.timerFiveInput == $past(port1PinIn[3]))                             // [R10]
		else $error("second port timer inputs misrouted");
	a_serial_two_route: assert property (port1OutputControl_ff[0] && port1OutputLatch_ff[0] ##1
		1'b1 |-> port1PinOut[0] == $past(altOut.serialOutTwo) && altIn_ff.serialInTwo == $past(port1PinIn[1]))  // [R11]
		else $error("serial 2 pins misrouted");
	a_boot_select: assert property (testPin[*2] |=> bootRomSel_ff && mode_ff == lip_pkg::LIP_MODE_PROM)  // [R13]
		else $error("boot memory not selected in programming mode");
	a_write_response: assert property (awTake ##0 wTake |-> ##2 s_axi_bvalid)
		else $error("write response late");

	c_write_port0: cover property (wrEn && awAddr_ff == lip_pkg::OFS_P0_CTRL);
	c_read_pins: cover property (arTake && s_axi_araddr == lip_pkg::OFS_P1_PINS);
	c_prom_mode: cover property (bootRomSel_ff);
	c_bad_addr: cover property (s_axi_bvalid && s_axi_bresp == lip_pkg::RESP_SLVERR);

endmodule // lip_gpio_top

/* core/lip_pin_slice.sv */
// Pin driver slice for one latched port: drive, release and read back.
// Assumes pin inputs synchronous to core_clk; outer logic resolves the wire.
`timescale 1ns/1ps
module lip_pin_slice #(
	parameter int W = 8
) (
	input  wire logic         core_clk,   // Core clock
	input  wire logic         sys_rst,    // Sync reset, active high
	input  wire logic [W-1:0] latchBits,  // Output latch
	input  wire logic [W-1:0] ctrlBits,   // Output control, 1 = push-pull
	input  wire logic [W-1:0] altOut,     // Peripheral drive, 1 when idle
	input  wire logic [W-1:0] pinIn,      // Pin level
	output logic      [W-1:0] pinOut,     // Pin drive value
	output logic      [W-1:0] pinOe,      // Pin drive enable
	output logic      [W-1:0] pinRead     // Sampled pin level
);

	// ==========================================================
	// Elaboration check
	if (W < 1 || W > 8) begin : g_bad_w
		$error("lip_pin_slice: W must be 1..8");
	end

	logic [W-1:0] driveVal;

	// Latch gated by peripheral drive
	assign driveVal = latchBits & altOut;

	// Push-pull when control set, else drive low only
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			pinOut <= '0;
			pinOe  <= '0;
		end else begin
			pinOut <= driveVal & ctrlBits;
			pinOe  <= ctrlBits | ~driveVal;
		end
	end

	// Read-back of pin level
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			pinRead <= '0;
		end else begin
			pinRead <= pinIn;
		end
	end

endmodule // lip_pin_slice

/* core/lip_pkg.sv */
// Shared constants and carrier types for the latched I/O port block.
// Assumes AXI4-Lite register access with 32-bit data and one core clock.
package lip_pkg;

	// ==========================================================
	// Bus and register map
	localparam int          ADDR_W        = 8;
	localparam int          DATA_W        = 32;
	localparam logic [7:0]  OFS_P0_LATCH  = 8'h00;
	localparam logic [7:0]  OFS_P0_CTRL   = 8'h04;
	localparam logic [7:0]  OFS_P0_PINS   = 8'h08;
	localparam logic [7:0]  OFS_P1_LATCH  = 8'h0C;
	localparam logic [7:0]  OFS_P1_CTRL   = 8'h10;
	localparam logic [7:0]  OFS_P1_PINS   = 8'h14;
	localparam logic [7:0]  OFS_P2_LATCH  = 8'h18;
	localparam logic [7:0]  OFS_P2_CTRL   = 8'h1C;
	localparam logic [7:0]  OFS_P2_PINS   = 8'h20;
	localparam logic [7:0]  OFS_MODE      = 8'h24;
	localparam logic [1:0]  RESP_OKAY     = 2'h0;
	localparam logic [1:0]  RESP_SLVERR   = 2'h2;

	// ==========================================================
	// Port widths and reset values
	localparam int          P0_W          = 8;
	localparam int          P1_W          = 6;
	localparam int          P2_W          = 4;
	localparam logic [7:0]  P0_LATCH_RST  = 8'hFF;
	localparam logic [7:0]  P0_CTRL_RST   = 8'h00;
	localparam logic [5:0]  P1_LATCH_RST  = 6'h3F;
	localparam logic [5:0]  P1_CTRL_RST   = 6'h00;
	localparam logic [3:0]  P2_LATCH_RST  = 4'hF;
	localparam logic [3:0]  P2_CTRL_RST   = 4'h0;

	// ==========================================================
	// Alternate function bit positions
	localparam int          B0_SER_CLK_ONE  = 7;
	localparam int          B0_SER_OUT_ONE  = 6;
	localparam int          B0_SER_IN_ONE   = 5;
	localparam int          B0_TMR_TWO      = 3;
	localparam int          B0_IRQ2         = 2;
	localparam int          B0_IRQ1         = 1;
	localparam int          B0_IRQ0         = 0;
	localparam int          B1_TMR_ONE      = 5;
	localparam int          B1_TMR_THREE    = 4;
	localparam int          B1_TMR_FIVE     = 3;
	localparam int          B1_SER_CLK_TWO  = 2;
	localparam int          B1_SER_IN_TWO   = 1;
	localparam int          B1_SER_OUT_TWO  = 0;
	localparam int          MODE_BIT      = 0;

	// ==========================================================
	// Operating mode and peripheral carriers
	typedef enum logic {LIP_MODE_MCU, LIP_MODE_PROM} lip_mode_t;

	typedef struct packed {
		logic serialClockOne;           // Serial clock 1 drive, 1 when idle
		logic serialOutOne;             // UART TX / serial out 1
		logic timerFiveWave;            // PWM or divider output of timer 5
		logic serialClockTwo;           // Serial clock 2 drive, 1 when idle
		logic serialOutTwo;             // Serial out 2
	} lip_alt_out_t;

	typedef struct packed {
		logic serialClockOne;
		logic serialInOne;
		logic timerTwoInput;
		logic extIrqTwo;
		logic extIrqOne;
		logic extIrqZero;
		logic timerOneInput;
		logic timerThreeInput;
		logic extIrqThree;
		logic timerFiveInput;
		logic serialClockTwo;
		logic serialInTwo;
	} lip_alt_in_t;

endpackage

/* testbench/latched_io_ports_with_alt_functions_tb_top.sv */
// Self-checking bench for the latched port block.
// Assumes the board model resolves wires; responses always accepted.
`timescale 1ns/1ps
module latched_io_ports_with_alt_functions_tb_top;
	logic core_clk, sys_rst, awv, awr, wv, wr, bv, arv, arr, rv, testPin, boot;
	logic [7:0] awa, ara, o0, e0, x0, l0;
	logic [31:0] wd, rd, q, v;
	logic [1:0] br, rr, rsp;
	logic [5:0] o1, e1, x1, l1;
	logic [3:0] o2, e2, x2, l2;
	lip_pkg::lip_alt_out_t alt;
	lip_pkg::lip_alt_in_t ain, xa;
	int fails, cmp_count, cyc;
	logic [7:0] t[6] = '{8'h00, 8'h04, 8'h0C, 8'h10, 8'h18, 8'h1C};
	logic [7:0] tr[6] = '{8'hFF, 8'h00, 8'h3F, 8'h00, 8'h0F, 8'h00};

	lip_gpio_top dut (.core_clk(core_clk), .sys_rst(sys_rst), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
		.s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr),
		.s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(1'b1), .s_axi_araddr(ara), .s_axi_arvalid(arv),
		.s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(1'b1),
		.port0PinIn(l0), .port0PinOut(o0), .port0PinOe(e0), .port1PinIn(l1), .port1PinOut(o1),
		.port1PinOe(e1), .port2PinIn(l2), .port2PinOut(o2), .port2PinOe(e2), .altOut(alt),
		.altIn_ff(ain), .testPin(testPin), .bootRomSel_ff(boot));
	lip_board_model brd (.p0Out(o0), .p0Oe(e0), .p1Out(o1), .p1Oe(e1), .p2Out(o2), .p2Oe(e2),
		.ext0(x0), .ext1(x1), .ext2(x2), .lvl0(l0), .lvl1(l1), .lvl2(l2));

	// ==========================================================
	// Clock and hang guard
	initial begin
		core_clk = 0;
		forever #5 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fails++;
			give_verdict();
		end
	end

	// ==========================================================
	// Bus cycles, comparisons, expectations
	task automatic axiWrite(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		bit aw, w;
		aw = 0;
		w = 0;
		awa <= a;
		wd <= d;
		awv <= 1;
		wv <= 1;
		while (!(aw && w)) begin
			@(posedge core_clk);
			if (!aw && awr === 1) begin
				aw = 1;
				awv <= 0;
			end
			if (!w && wr === 1) begin
				w = 1;
				wv <= 0;
			end
		end
		do @(posedge core_clk); while (bv !== 1);
		r = br;
	endtask
	task automatic axiRead(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		ara <= a;
		arv <= 1;
		do @(posedge core_clk); while (arr !== 1);
		arv <= 0;
		do @(posedge core_clk); while (rv !== 1);
		d = rd;
		r = rr;
	endtask
	task automatic chkWord(input string n, input logic [31:0] x, input logic [31:0] g);
		cmp_count++;
		if (g !== x) begin
			fails++;
			$display("Error %s expected %h seen %h", n, x, g);
		end
	endtask
	task automatic chkResp(input string n, input logic [1:0] x, input logic [1:0] g);
		cmp_count++;
		if (g !== x) begin
			fails++;
			$display("Error %s expected %h seen %h", n, x, g);
		end
	endtask
	task automatic give_verdict();
		$display("Comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic wrOk(input logic [7:0] a, input logic [31:0] d);
		axiWrite(a, d, rsp);
		chkResp("bresp", lip_pkg::RESP_OKAY, rsp);
	endtask
	task automatic waitN(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	function automatic lip_pkg::lip_alt_in_t expAlt(input logic [7:0] p, input logic [5:0] s);
		return {p[7], p[5], p[3], p[2], p[1], p[0], s[5], s[4], s[4], s[3], s[2], s[1]};
	endfunction

	// ==========================================================
	// Main sequence
	initial begin
		{awv, wv, arv, awa, ara, wd, testPin, cyc, fails, cmp_count} = '0;
		alt = '1;
		{x0, x1, x2} = '0;
		sys_rst = 1;
		void'($urandom(60));
		waitN(20);
		sys_rst <= 0;
		waitN(1);
		// Reset values and released pins
		for (int i = 0; i < 6; i++) begin
			axiRead(t[i], q, rsp);
			chkWord("reset reg", {24'h0, tr[i]}, q);
		end
		chkWord("reset oe", 32'h0, {e0, e1, e2});
		// Push-pull with random latches, plain values only
		repeat (4) begin
			q = $urandom;
			wrOk(8'h00, q);
			wrOk(8'h0C, q >> 8);
			wrOk(8'h18, q >> 16);
			wrOk(8'h04, 32'hFF);
			wrOk(8'h10, 32'h3F);
			wrOk(8'h1C, 32'h0F);
			waitN(2);
			chkWord("pin out", {q[7:0], q[13:8], q[19:16]}, {o0, o1, o2});
			chkWord("pin oe", {8'hFF, 6'h3F, 4'hF}, {e0, e1, e2});
			axiRead(8'h0C, v, rsp);
			chkWord("latch1 read", {26'h0, q[13:8]}, v);
		end
		// Peripheral drive through latches set to one
		wrOk(8'h00, 32'hFF);
		wrOk(8'h0C, 32'h3F);
		repeat (3) begin
			alt <= 5'($urandom);
			waitN(3);
			chkWord("alt out0", {alt.serialClockOne, alt.serialOutOne, 6'h3F}, o0);
			chkWord("alt out1", {2'h3, alt.timerFiveWave, alt.serialClockTwo, 1'b1, alt.serialOutTwo}, o1);
		end
		alt <= '1;
		// Release and read back outside levels
		wrOk(8'h18, 32'h0F);
		wrOk(8'h04, 32'h00);
		wrOk(8'h10, 32'h00);
		wrOk(8'h1C, 32'h00);
		repeat (3) begin
			{x0, x1, x2} <= 18'($urandom);
			waitN(3);
			chkWord("released oe", 32'h0, {e0, e1, e2});
			xa = expAlt(x0, x1);
			chkWord("alt in", xa, ain);
			axiRead(8'h08, q, rsp);
			chkWord("pins0", {24'h0, x0}, q);
			axiRead(8'h14, q, rsp);
			chkWord("pins1", {26'h0, x1}, q);
			axiRead(8'h20, q, rsp);
			chkWord("pins2", {28'h0, x2}, q);
		end
		// Latch zero with control zero pulls low
		q = 32'h5A;
		wrOk(8'h00, q);
		waitN(2);
		chkWord("od oe", {24'h0, ~q[7:0]}, e0);
		chkWord("od out", 32'h0, o0);
		// Mode select
		testPin <= 1;
		waitN(3);
		chkWord("boot sel", 32'h1, boot);
		axiRead(8'h24, q, rsp);
		chkWord("mode reg", 32'h1, q);
		testPin <= 0;
		waitN(3);
		chkWord("boot sel", 32'h0, boot);
		// Unmapped place
		axiRead(8'h80, q, rsp);
		chkResp("rresp", lip_pkg::RESP_SLVERR, rsp);
		chkWord("unmapped", 32'h0, q);
		axiWrite(8'h80, 32'h1, rsp);
		chkResp("bresp", lip_pkg::RESP_SLVERR, rsp);
		give_verdict();
	end
endmodule // latched_io_ports_with_alt_functions_tb_top

/* testbench/lip_board_model.sv */
// Board-side model of the three port wires.
// Assumes the bench gives outside levels; a pin the port releases shows them.
`timescale 1ns/1ps
module lip_board_model (
	input  wire logic [7:0] p0Out, // First port drive
	input  wire logic [7:0] p0Oe,  // First port enable
	input  wire logic [5:0] p1Out, // Second port drive
	input  wire logic [5:0] p1Oe,  // Second port enable
	input  wire logic [3:0] p2Out, // Third port drive
	input  wire logic [3:0] p2Oe,  // Third port enable
	input  wire logic [7:0] ext0,  // Outside levels, first port
	input  wire logic [5:0] ext1,  // Outside levels, second port
	input  wire logic [3:0] ext2,  // Outside levels, third port
	output logic      [7:0] lvl0,  // Resolved first port wire
	output logic      [5:0] lvl1,  // Resolved second port wire
	output logic      [3:0] lvl2   // Resolved third port wire
);
	// ==========================================================
	// Wire resolution: released bits take the outside level
	assign lvl0 = (p0Oe & p0Out) | (~p0Oe & ext0);
	assign lvl1 = (p1Oe & p1Out) | (~p1Oe & ext1);
	assign lvl2 = (p2Oe & p2Out) | (~p2Oe & ext2);
endmodule // lip_board_model
